// file: hdl/udc_pkg.sv
// Package for the presettable 4-bit up/down counter
// Assumes a single 125 MHz clock domain
package udc_pkg;

  // ----------------------------------------
  // Widths and values
  // ----------------------------------------
  localparam int          UDC_WIDTH     = 4;
  localparam logic [3:0]  UDC_RST_COUNT = 4'h0;
  localparam logic [3:0]  UDC_TOP_COUNT = 4'hf;
  localparam logic [3:0]  UDC_BOT_COUNT = 4'h0;
  localparam int          UDC_SYNC_LEN  = 2;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic       load_strobe;
    logic       wipe;
    logic       up_select;
    logic       cascade_n;
    logic [3:0] load_value;
  } udc_ctrl_type;

  typedef enum logic [1:0] {
    UDC_MODE_WIPE  = 2'b00,
    UDC_MODE_LOAD  = 2'b01,
    UDC_MODE_HOLD  = 2'b10,
    UDC_MODE_COUNT = 2'b11
  } udc_mode_type;

endpackage

// file: hdl/udc_sync.sv
// Two-flop synchroniser for a bundle of pin levels
// Assumes inputs arrive from outside the clock domain
`timescale 1ns/1ns
module udc_sync
  import udc_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         nrst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

// file: hdl/udc_counter.sv
// Presettable 4-bit binary up/down counter with cascade carry
// Assumes control pins are asynchronous and are synchronised here
// Operation
// - High load strobe copies load value into count on a rising edge
// - High wipe forces count to zero on a rising edge, over load
// - High cascade enable input freezes count; low lets it count
// - Each enabled rising edge steps count by one
// - Direction high counts up, low counts down
// - Count is 4-bit binary, lowest output bit is least significant
// - Terminal-count output is low while count sits at 15 up or 0 down and cascade enable is low
// - Count wraps modulo 16 and keeps its direction
// - Counting resumes from loaded value; frozen stage holds
`timescale 1ns/1ns
module udc_counter
  import udc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       load_strobe_in,
  input  wire logic       wipe_in,
  input  wire logic       up_select_in,
  input  wire logic       cascade_n_in,
  input  wire logic [3:0] load_value_in,
  output logic      [3:0] count_out,
  output logic            carry_n_out
);

  udc_ctrl_type ctrl_raw;
  udc_ctrl_type ctrl_s;
  udc_mode_type mode;
  logic [3:0]   count_r;
  logic [3:0]   count_nxt;
  logic [3:0]   toggle;
  logic         carry_n_r;
  logic         carry_n_nxt;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  assign ctrl_raw = '{load_strobe: load_strobe_in,
                      wipe:        wipe_in,
                      up_select:   up_select_in,
                      cascade_n:   cascade_n_in,
                      load_value:  load_value_in};

  udc_sync #(
    .W($bits(udc_ctrl_type))
  ) u_sync (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .async_in(ctrl_raw),
    .sync_out(ctrl_s)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic at_terminal(input logic [3:0] v, input logic up);
    at_terminal = up ? (v == UDC_TOP_COUNT) : (v == UDC_BOT_COUNT);
  endfunction

  // Toggle mask for synchronous binary up/down stepping
  function automatic logic [3:0] toggle_mask(input logic [3:0] v, input logic up);
    logic [3:0] m;
    m = 4'h0;
    m[0] = 1'b1;
    for (int i = 1; i < UDC_WIDTH; i++) begin
      m[i] = m[i-1] & (up ? v[i-1] : ~v[i-1]);
    end
    toggle_mask = m;
  endfunction

  // ----------------------------------------
  // Mode priority
  // ----------------------------------------
  always_comb begin
    if (ctrl_s.wipe) begin
      mode = UDC_MODE_WIPE;
    end else if (ctrl_s.load_strobe) begin
      mode = UDC_MODE_LOAD;
    end else if (ctrl_s.cascade_n) begin
      mode = UDC_MODE_HOLD;
    end else begin
      mode = UDC_MODE_COUNT;
    end
  end

  // ----------------------------------------
  // Count next value
  // ----------------------------------------
  always_comb begin
    toggle    = toggle_mask(count_r, ctrl_s.up_select);
    count_nxt = count_r;
    unique case (mode)
      UDC_MODE_WIPE:  count_nxt = UDC_RST_COUNT;
      UDC_MODE_LOAD:  count_nxt = ctrl_s.load_value;
      UDC_MODE_HOLD:  count_nxt = count_r;
      UDC_MODE_COUNT: count_nxt = count_r ^ toggle;
    endcase
  end

  // ----------------------------------------
  // Terminal count next value
  // ----------------------------------------
  // Carry follows cascade input and the terminal value in every mode
  always_comb begin
    carry_n_nxt = 1'b1;
    if (!ctrl_s.cascade_n &&
        at_terminal(count_nxt, ctrl_s.up_select)) begin
      carry_n_nxt = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      count_r   <= UDC_RST_COUNT;
      carry_n_r <= 1'b1;
    end else begin
      count_r   <= count_nxt;
      carry_n_r <= carry_n_nxt;
    end
  end

  assign count_out   = count_r;
  assign carry_n_out = carry_n_r;

endmodule

// file: testbench/udc_counter_monitor.sv
// Port checks for the up/down counter
// Assumes inputs reach the count three edges late
`timescale 1ns/1ns
module udc_counter_monitor
  import udc_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic       load_strobe_in,
  input wire logic       wipe_in,
  input wire logic       up_select_in,
  input wire logic       cascade_n_in,
  input wire logic [3:0] load_value_in,
  input wire logic [3:0] count_out,
  input wire logic       carry_n_out
);
  udc_ctrl_type c1, c2, c3;
  logic [2:0]   rv;
  logic         run;
  always_ff @(posedge clk_in) begin
    c1 <= {load_strobe_in, wipe_in, up_select_in, cascade_n_in, load_value_in};
    c2 <= c1;
    c3 <= c2;
    rv <= {rv[1:0], nrst_in};
  end
  assign run = rv[2] & ~c3.wipe & ~c3.load_strobe & ~c3.cascade_n;
  // ----
  // Checks
  // ----
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wipe_zero_a: assert property (rv[2] && c3.wipe |-> count_out == 4'h0)
    else $error("count not cleared");
  load_copy_a: assert property (rv[2] && !c3.wipe && c3.load_strobe
    |-> count_out == c3.load_value) else $error("load not copied");
  hold_count_a: assert property (rv[2] && !c3.wipe && !c3.load_strobe
    && c3.cascade_n |-> $stable(count_out)) else $error("count moved");
  count_up_a: assert property (run && c3.up_select
    |-> count_out == $past(count_out) + 4'h1) else $error("bad up step");
  count_down_a: assert property (run && !c3.up_select
    |-> count_out == $past(count_out) - 4'h1) else $error("bad down step");
  carry_term_a: assert property (rv[2] |-> !carry_n_out == (!c3.cascade_n
    && count_out == (c3.up_select ? 4'hf : 4'h0))) else $error("bad carry");
  carry_pulse_a: assert property (!carry_n_out ##1 run |-> carry_n_out)
    else $error("carry too long");
  carry_idle_a: assert property (rv[2] && c3.cascade_n |-> carry_n_out)
    else $error("carry while gated");
  cover property (!carry_n_out && c3.up_select);
  cover property (run && !c3.up_select);
  cover property (rv[2] && c3.load_strobe);
endmodule
bind udc_counter udc_counter_monitor udc_counter_monitor_i (.*);

// file: testbench/udc_stage_model.sv
// Next cascaded stage, counts on low carry
// Assumes the shared clock and direction
`timescale 1ns/1ns
module udc_stage_model
  import udc_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       wipe_in,
  input  wire logic       up_in,
  input  wire logic       cin_n_in,
  output logic      [3:0] hi_out
);
  always_ff @(posedge clk_in) begin
    if (wipe_in) hi_out <= 4'h0;
    else if (!cin_n_in) hi_out <= up_in ? hi_out + 4'h1 : hi_out - 4'h1;
  end
endmodule

// file: testbench/udc_counter_tb_top.sv
// Bench for the up/down counter
// Assumes three-edge input lag
`timescale 1ns/1ns
module udc_counter_tb_top
  import udc_pkg::*;
;
  logic clk_in = 0, nrst_in = 0, carry_n_out;
  logic [3:0] count_out, hi;
  udc_ctrl_type c = '0;
  int num_errors = 0, samples_checked = 0, cyc = 0;
  initial forever #4 clk_in = ~clk_in;
  udc_counter udc_counter_i (.clk_in(clk_in), .nrst_in(nrst_in),
    .load_strobe_in(c.load_strobe), .wipe_in(c.wipe), .up_select_in(c.up_select),
    .cascade_n_in(c.cascade_n), .load_value_in(c.load_value),
    .count_out(count_out), .carry_n_out(carry_n_out));
  udc_stage_model udc_stage_model_i (.clk_in(clk_in), .wipe_in(c.wipe),
    .up_in(c.up_select), .cin_n_in(carry_n_out), .hi_out(hi));
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task go(input udc_ctrl_type v, input int n);
    @(posedge clk_in);
    #1 c = v;
    repeat (n) @(posedge clk_in);
    #2;
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 500) begin
      num_errors++;
      give_verdict;
    end
  end
  task test_load;
    go(8'h95, 3); chk("count", 4'h5, count_out);
    go(8'ha5, 4); chk("count", 4'h5, count_out);
    $display("test load done");
  endtask
  task test_wipe;
    go(8'hc9, 3); chk("count", 4'h0, count_out);
    chk("carry", 4'h0, {3'h0, carry_n_out});
    $display("test wipe done");
  endtask
  task test_up;
    go(8'hae, 3); go(8'h20, 3); chk("count", 4'hf, count_out);
    chk("carry", 4'h0, {3'h0, carry_n_out});
    go(c, 0); chk("count", 4'h0, count_out);
    chk("carry", 4'h1, {3'h0, carry_n_out});
    $display("test up done");
  endtask
  task test_hold;
    go(8'h97, 3); go(8'h37, 5); chk("count", 4'h7, count_out);
    chk("carry", 4'h1, {3'h0, carry_n_out});
    $display("test hold done");
  endtask
  task test_down;
    go(8'h81, 3); go(8'h00, 3); chk("count", 4'h0, count_out);
    chk("carry", 4'h0, {3'h0, carry_n_out});
    go(c, 0); chk("count", 4'hf, count_out);
    $display("test down done");
  endtask
  task test_cascade;
    go(8'h50, 3); go(8'h20, 18); chk("count", 4'h0, count_out);
    chk("upper", 4'h1, hi);
    $display("test cascade done");
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    #1 nrst_in = 1;
    test_load;
    test_wipe;
    test_up;
    test_hold;
    test_down;
    test_cascade;
    give_verdict;
  end
endmodule
